// ### shared/rcs_pkg.sv
// Summary of operation
// - pll on doubles 2-4 MHz input clock
// - pll off: internal clock is raw/2
// - option picks one of seven clock sources
// - resonators keep running except while rst_n is low
// - three sources; pin low through delay
// - vector fetched from fffe then ffff
// - active, delay 256/4096, then fetch
// - vector fetch lasts exactly two cycles
// - pin is input and open-drain output
// - pin low caught without running clock
// - recognised pin pulse stretched to minimum
// - watchdog underflow drives pin, runs sequence
// - undervoltage holds reset and pin low
// - undervoltage resets only when option enabled
// - undervoltage reset flag bit4, write-zero clear
package rcs_pkg;

    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned OUT_PULSE_NS = 1000;
    localparam int unsigned IN_PULSE_NS = 20;
    localparam int unsigned DLY_SHORT = 256;
    localparam int unsigned DLY_LONG = 4096;
    localparam int unsigned FETCH_CYC = 2;
    localparam int unsigned GUARD_CYC = 4;
    localparam logic [15:0] VEC_LO = 16'hfffe;
    localparam logic [15:0] VEC_HI = 16'hffff;

    // ------------------------------------------------
    // register map and fields
    // ------------------------------------------------
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_MASK = 8'h04;
    localparam logic [7:0] A_SICR = 8'h08;
    localparam logic [7:0] A_PHASE = 8'h0c;
    localparam int unsigned EV_EXT = 0;
    localparam int unsigned EV_LV = 1;
    localparam int unsigned EV_WDG = 2;
    localparam int unsigned EV_CFG = 3;
    localparam int unsigned SI_WDG_RF = 0;
    localparam int unsigned SI_LV_RF = 4;
    localparam logic [3:0] EV_RST = 4'h0;
    localparam logic [7:0] SI_RST = 8'h00;

    // ------------------------------------------------
    // types
    // ------------------------------------------------
    typedef enum logic [2:0] {
        OSC_EXT, OSC_XT0, OSC_XT1, OSC_XT2, OSC_XT3,
        OSC_EXT_RC, OSC_INT_RC
    } rcs_osc_e;

    typedef enum logic [1:0] {
        PH_RUN, PH_ACTIVE, PH_DELAY, PH_FETCH
    } rcs_phase_e;

    typedef struct packed {
        logic pll_en;
        logic lv_rst_en;
        logic long_dly;
        rcs_osc_e osc_sel;
    } rcs_opt_s;

    typedef struct packed {
        logic osc_run;
        logic pll_on;
        logic div2;
        rcs_osc_e sel;
    } rcs_clk_s;

    // cycles from ns: least time rounds up, never below one
    function automatic int unsigned ns_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c == 0) ? 1 : c;
    endfunction

endpackage

// ### hw/rcs_top.sv
`timescale 1ns/1ps
module rcs_top #(
    parameter int unsigned OUT_NS = rcs_pkg::OUT_PULSE_NS,
    parameter int unsigned IN_NS = rcs_pkg::IN_PULSE_NS,
    parameter int unsigned D_SHORT = rcs_pkg::DLY_SHORT,
    parameter int unsigned D_LONG = rcs_pkg::DLY_LONG
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output logic irq,
    // nonvolatile option settings
    input wire rcs_pkg::rcs_opt_s opt_in,
    // reset pin, undervoltage, watchdog
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic lv_low,
    input wire logic wdg_underflow,
    // cpu side
    output logic cpu_rst_n,
    output logic vec_fetch,
    output logic [15:0] vec_addr,
    output rcs_pkg::rcs_clk_s clk_ctl
);
    import rcs_pkg::*;

    // pulse widths in clock cycles, rounded up
    localparam int unsigned OUT_CYC = ns_cyc(OUT_NS);
    localparam int unsigned IN_CYC = ns_cyc(IN_NS);
    localparam int CW = 13;

    // ------------------------------------------------
    // elaboration checks
    // ------------------------------------------------
    // counters are CW bits wide; larger counts would wrap
    if (D_LONG >= (1 << CW) || OUT_CYC >= (1 << CW)
        || IN_CYC >= (1 << CW) || D_SHORT == 0
        || D_SHORT > D_LONG) begin : g_bad
        $error("rcs_top: counts out of range");
    end

    // sequence state and source capture flops
    rcs_phase_e phase;
    rcs_opt_s opt;
    logic [CW-1:0] cnt;
    logic [CW-1:0] low_cnt;
    logic [2:0] guard;
    logic pin_s1, pin_s2;
    logic lv_s1, lv_s2;
    logic catch_q, catch_s1, catch_s2;
    logic [3:0] ev;
    logic [3:0] mask;
    logic [7:0] sicr;
    logic cfg_bad;
    logic ext_req, lv_req, wdg_req, any_req;
    logic wb_hit;
    logic rd_status;

    // ------------------------------------------------
    // option capture and clock control
    // ------------------------------------------------
    // options are latched while reset is held, so a
    // change of option needs a new system reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            opt <= opt_in;
        end
    end

    // pll with external clock or internal rc is illegal
    assign cfg_bad = opt.pll_en
        && (opt.osc_sel == OSC_EXT || opt.osc_sel == OSC_INT_RC);

    // clock steering toward the oscillator cell
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_ctl <= '0;
        end else begin
            clk_ctl.sel <= opt.osc_sel;
            // refused pairing falls back to the divider
            clk_ctl.pll_on <= opt.pll_en && !cfg_bad;
            clk_ctl.div2 <= !(opt.pll_en && !cfg_bad);
            // resonators stop only while rst_n is low, so no restart delay
            clk_ctl.osc_run <= (opt.osc_sel inside {OSC_XT0,
                OSC_XT1, OSC_XT2, OSC_XT3})
                || phase == PH_RUN;
        end
    end

    // ------------------------------------------------
    // source capture
    // ------------------------------------------------
    // async catcher sets with no clock, so a pulse
    // during a stopped clock is still remembered
    always_ff @(posedge sys_clk or negedge rst_pin_in) begin
        if (!rst_pin_in) begin
            catch_q <= 1'b1;
        end else if (!rst_n || phase != PH_RUN
                     || guard != 3'h0) begin
            catch_q <= 1'b0;
        end
    end

    // two-flop synchronisers for pin, catcher, detector
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
            catch_s1 <= 1'b0;
            catch_s2 <= 1'b0;
            lv_s1 <= 1'b0;
            lv_s2 <= 1'b0;
        end else begin
            pin_s1 <= rst_pin_in;
            pin_s2 <= pin_s1;
            catch_s1 <= catch_q;
            catch_s2 <= catch_s1;
            lv_s1 <= lv_low;
            lv_s2 <= lv_s1;
        end
    end

    // low-time counter; pin is only judged while idle
    always_ff @(posedge sys_clk) begin
        if (!rst_n || phase != PH_RUN || pin_s2) begin
            low_cnt <= '0;
        end else if (low_cnt != CW'(IN_CYC)) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    // settle time after release, as the pin rises late
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            guard <= 3'h0;
        end else if (phase == PH_FETCH) begin
            guard <= 3'(GUARD_CYC);
        end else if (guard != 3'h0) begin
            guard <= guard - 1'b1;
        end
    end

    // the low-time filter rejects short glitches; the catcher
    // keeps any pulse that fell in run once guard is zero, so halt wake-up was
    // traded against glitch immunity on that path
    assign ext_req = phase == PH_RUN && guard == 3'h0
        && (low_cnt == CW'(IN_CYC) || catch_s2);
    assign lv_req = lv_s2 && opt.lv_rst_en;
    assign wdg_req = wdg_underflow;
    // our own drive masks the pin outside the idle phase
    assign any_req = ext_req || lv_req || wdg_req;

    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    // active: at least the output width, longer while
    // undervoltage lasts; delay; two-cycle fetch
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase <= PH_ACTIVE;
            cnt <= '0;
        end else if (any_req) begin
            phase <= PH_ACTIVE;
            cnt <= '0;
        end else begin
            unique case (phase)
                PH_RUN: begin
                    cnt <= '0;
                end
                PH_ACTIVE: begin
                    if (cnt >= CW'(OUT_CYC - 1)) begin
                        phase <= PH_DELAY;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                PH_DELAY: begin
                    if (cnt == (opt.long_dly ? CW'(D_LONG - 1)
                                : CW'(D_SHORT - 1))) begin
                        phase <= PH_FETCH;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                PH_FETCH: begin
                    if (cnt == CW'(FETCH_CYC - 1)) begin
                        phase <= PH_RUN;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    // pin and cpu outputs, one cycle behind the phase
    // cpu_rst_n also drops in the cycle of a request, one edge ahead of the pin, or on the same edge for undervoltage
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b0;
            cpu_rst_n <= 1'b0;
            vec_fetch <= 1'b0;
            vec_addr <= VEC_LO;
        end else begin
            rst_pin_out <= 1'b0;
            // open drain: pulled low through active and delay
            rst_pin_oe_n <= !(phase == PH_ACTIVE
                || phase == PH_DELAY || lv_req);
            cpu_rst_n <= phase == PH_RUN && !any_req;
            vec_fetch <= phase == PH_FETCH && !any_req;
            vec_addr <= (phase == PH_FETCH && cnt[0])
                ? VEC_HI : VEC_LO;
        end
    end

    // ------------------------------------------------
    // wishbone slave
    // ------------------------------------------------
    // a request is taken only while ack is low, so the cycle after ack is idle
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_status = wb_hit && !wb_we_i && wb_adr_i == A_STATUS;

    // one wait state; unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= '0;
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i)
                    A_STATUS: wb_dat_o <= {28'h0, ev};
                    A_MASK: wb_dat_o <= {28'h0, mask};
                    A_SICR: wb_dat_o <= {24'h0, sicr};
                    A_PHASE: wb_dat_o <= {24'h0, opt, phase};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // mask register, low byte lane only
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mask <= EV_RST;
        end else if (wb_hit && wb_we_i && wb_adr_i == A_MASK
                     && wb_sel_i[0]) begin
            mask <= wb_dat_i[3:0];
        end
    end

    // cause flags: hardware set beats a software zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sicr <= SI_RST;
        end else begin
            if (wb_hit && wb_we_i && wb_adr_i == A_SICR
                && wb_sel_i[0]) begin
                sicr[SI_LV_RF] <= wb_dat_i[SI_LV_RF] & sicr[SI_LV_RF];
                sicr[SI_WDG_RF] <= wb_dat_i[SI_WDG_RF] & sicr[SI_WDG_RF];
            end
            if (lv_req) begin
                sicr[SI_LV_RF] <= 1'b1;
            end
            if (wdg_req) begin
                sicr[SI_WDG_RF] <= 1'b1;
            end
        end
    end

    // sticky events cleared by a status read; set wins
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ev <= EV_RST;
        end else begin
            ev <= (rd_status ? 4'h0 : ev)
                | {cfg_bad, wdg_req, lv_req, ext_req};
        end
    end

    // level interrupt
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev & mask);
        end
    end

endmodule

// ### dv/rcs_pin_model.sv
`timescale 1ns/1ps
module rcs_pin_model (
    input wire logic sys_clk,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    output logic rst_pin_in
);
    logic ext_low = 1'b0;

    // wired-and of the device driver and the outside switch; weak pull-up when nobody pulls
    assign rst_pin_in = ext_low ? 1'b0 : (rst_pin_oe_n ? 1'b1 : rst_pin_out);

    // outside switch; callers keep it long enough to be recognised
    task automatic press(input int unsigned n);
        ext_low <= 1'b1;
        repeat (n) @(posedge sys_clk);
        ext_low <= 1'b0;
    endtask
endmodule

// ### dv/rcs_chk_properties.sv
`timescale 1ns/1ps
module rcs_chk #(
    parameter int unsigned OUT_NS = 1000,
    parameter int unsigned D_SHORT = 256,
    parameter int unsigned D_LONG = 4096
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire rcs_pkg::rcs_opt_s opt_in,
    input wire logic rst_pin_in,
    input wire logic rst_pin_out,
    input wire logic rst_pin_oe_n,
    input wire logic lv_low,
    input wire logic wdg_underflow,
    input wire logic cpu_rst_n,
    input wire logic vec_fetch,
    input wire logic [15:0] vec_addr,
    input wire rcs_pkg::rcs_clk_s clk_ctl
);
    import rcs_pkg::*;
    localparam int unsigned OUT_CYC = (OUT_NS * 200 + 999) / 1000;
    int unsigned lo_cnt;

    // cycles spent in reset; slack of two covers the output lag
    always_ff @(posedge sys_clk) begin
        lo_cnt <= (!rst_n || cpu_rst_n) ? 0 : lo_cnt + 1;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_fetch_pair: assert property (
        $rose(vec_fetch) |-> vec_addr == VEC_LO ##1 vec_fetch && vec_addr == VEC_HI
        ##1 !vec_fetch && cpu_rst_n) else $error("vector fetch sequence wrong");
    chk_delay_len: assert property (
        $rose(vec_fetch) |-> lo_cnt + 2 >= OUT_CYC + (opt_in.long_dly ? D_LONG : D_SHORT))
        else $error("reset delay too short");
    chk_pin_delay: assert property (
        $rose(vec_fetch) |-> !$past(rst_pin_oe_n)) else $error("pin released before fetch");
    chk_pin_stretch: assert property (
        $fell(rst_pin_oe_n) |-> !rst_pin_oe_n [*8]) else $error("pin pulse too short");
    chk_wdg_resp: assert property (
        wdg_underflow |-> ##2 !rst_pin_oe_n && !cpu_rst_n) else $error("no watchdog reset");
    chk_pin_drive: assert property (
        !rst_pin_oe_n |-> !rst_pin_out) else $error("pin driven high");
    chk_lv_hold: assert property (
        (lv_low && opt_in.lv_rst_en) [*5] |-> !rst_pin_oe_n && !cpu_rst_n)
        else $error("undervoltage not held");
    chk_lv_off: assert property (
        (cpu_rst_n && !opt_in.lv_rst_en && rst_pin_in && !wdg_underflow) [*8] |=> cpu_rst_n)
        else $error("reset without cause");
    chk_clk_mode: assert property (
        cpu_rst_n |-> clk_ctl.sel == opt_in.osc_sel && clk_ctl.div2 != clk_ctl.pll_on
        && clk_ctl.pll_on == (opt_in.pll_en && !(opt_in.osc_sel inside {OSC_EXT, OSC_INT_RC})))
        else $error("clock mode wrong");
    chk_osc_run: assert property (
        $past(rst_n) && opt_in.osc_sel inside {OSC_XT0, OSC_XT1, OSC_XT2, OSC_XT3}
        |-> clk_ctl.osc_run) else $error("resonator stopped");

    cover property ($rose(vec_fetch));
    cover property (wdg_underflow);
    cover property ($fell(rst_pin_in));
    cover property (wdg_underflow && !cpu_rst_n);
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import rcs_pkg::*;
    localparam int unsigned OC = 4;
    localparam int unsigned DS = 16;
    localparam int unsigned DL = 32;
    logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, lv_low, wdg_underflow;
    logic rst_pin_in, rst_pin_out, rst_pin_oe_n, cpu_rst_n, vec_fetch;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [15:0] vec_addr;
    rcs_opt_s opt_in;
    rcs_clk_s clk_ctl;
    int err_total, compares, n;

    rcs_top #(.OUT_NS(20), .D_SHORT(DS), .D_LONG(DL)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq(irq), .opt_in(opt_in),
        .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n),
        .lv_low(lv_low), .wdg_underflow(wdg_underflow), .cpu_rst_n(cpu_rst_n),
        .vec_fetch(vec_fetch), .vec_addr(vec_addr), .clk_ctl(clk_ctl));
    rcs_pin_model pm (.sys_clk, .rst_pin_out, .rst_pin_oe_n, .rst_pin_in);

    always #2.5 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; only the bench watchdog bounds the wait
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(q, exp);
    endtask

    // counts cycles until the cpu runs and gathers fetch addresses
    task automatic run_wait();
        logic [15:0] v[$];
        n = 0;
        while (cpu_rst_n !== 1'b1 && n < 5000) begin
            @(posedge sys_clk);
            if (vec_fetch === 1'b1) v.push_back(vec_addr);
            n++;
        end
        check({v[0], v[1]}, 32'hfffeffff);
    endtask

    task automatic boot(input rcs_opt_s o, input int unsigned d);
        rst_n <= 1'b0;
        opt_in <= o;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        run_wait();
        check(n > OC + d && n <= OC + d + 6, 1);
    endtask

    task automatic t_clk();
        logic pl;
        for (int i = 0; i < 7; i++) begin
            boot('{1'b1, 1'b0, 1'b0, rcs_osc_e'(i)}, DS);
            pl = !(i == 0 || i == 6);
            check(clk_ctl, {1'b1, pl, !pl, 3'(i)});
            rdc(A_STATUS, {!pl, 3'h0});
        end
        $display("test clk done");
    endtask

    task automatic t_wdg();
        boot('{1'b0, 1'b0, 1'b1, OSC_XT0}, DL);
        wb(1'b1, A_MASK, 32'h4);
        lv_low <= 1'b1;
        repeat (12) @(posedge sys_clk);
        check(cpu_rst_n, 1);
        lv_low <= 1'b0;
        wdg_underflow <= 1'b1;
        @(posedge sys_clk);
        wdg_underflow <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check({rst_pin_oe_n, rst_pin_in, cpu_rst_n}, 0);
        // a second underflow deep in the delay must restart the full sequence
        repeat (10) @(posedge sys_clk);
        wdg_underflow <= 1'b1;
        @(posedge sys_clk);
        wdg_underflow <= 1'b0;
        run_wait();
        check(n > OC + DL && n <= OC + DL + 6, 1);
        check(irq, 1);
        rdc(A_STATUS, 32'h4);
        check(irq, 0);
        rdc(A_STATUS, 32'h0);
        rdc(A_SICR, 32'h1);
        $display("test wdg done");
    endtask

    task automatic t_ext();
        boot('{1'b0, 1'b1, 1'b0, OSC_XT1}, DS);
        pm.press(6);
        repeat (3) @(posedge sys_clk);
        check({rst_pin_oe_n, rst_pin_in}, 0);
        run_wait();
        rdc(A_STATUS, 32'h1);
        lv_low <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check({rst_pin_oe_n, cpu_rst_n}, 0);
        lv_low <= 1'b0;
        repeat (3) @(posedge sys_clk);
        run_wait();
        rdc(A_SICR, 32'h10);
        wb(1'b1, A_SICR, 32'h0);
        rdc(A_SICR, 32'h0);
        rdc(8'h40, 32'h0);
        $display("test ext done");
    endtask

    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        end_sim();
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, lv_low, wdg_underflow} = '0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h1;
        opt_in = '0;
        @(posedge sys_clk);
        t_clk();
        t_wdg();
        t_ext();
        end_sim();
    end
endmodule

bind rcs_top rcs_chk #(.OUT_NS(OUT_NS), .D_SHORT(D_SHORT), .D_LONG(D_LONG)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .opt_in(opt_in), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .lv_low(lv_low),
    .wdg_underflow(wdg_underflow), .cpu_rst_n(cpu_rst_n), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr), .clk_ctl(clk_ctl));
